// ===== hdl/dcc_consts.svh
`ifndef DCC_CONSTS_SVH
`define DCC_CONSTS_SVH

`define DCC_FRAME_BITS      5'h10
`define DCC_BIT_MODE_HI     15
`define DCC_BIT_MODE_LO     14
`define DCC_BIT_PARITY      13
`define DCC_BIT_RW          12
`define DCC_BIT_SWR         11
`define DCC_BIT_SEL         10
`define DCC_FIELD_HI        9
`define DCC_FIELD_LO        8
`define DCC_LOW_HI          7

`define DCC_SEQ_FIRST       8'hAA
`define DCC_SEQ_SECOND      8'h55
`define DCC_MODE1_LOW       8'h02
`define DCC_RESET_DONE_RESP 16'h2003
`define DCC_INVALID_RESP    16'h2000
`define DCC_RESP_RESET      16'h2000

`define DCC_CL_DEFAULT      2'h0
`define DCC_LATCH_DEFAULT   2'h0

`define DCC_CUR_MA_1200     11'h4B0
`define DCC_CUR_MA_1500     11'h5DC
`define DCC_CUR_MA_1750     11'h6D6
`define DCC_TIME_US_2000    11'h7D0
`define DCC_TIME_US_650     11'h28A
`define DCC_TIME_US_1000    11'h3E8

`define DCC_CLK_KHZ         200000
`define DCC_STRETCH_UNIT_MS 128
`define DCC_STRETCH_UNIT_CYC (`DCC_STRETCH_UNIT_MS * `DCC_CLK_KHZ)
`define DCC_TIMER_BITS      27

`endif

// ===== hdl/dcc_pkg.sv
package dcc_pkg;
    typedef enum logic [3:0] {
        DCC_CMD_MODE1  = 4'h1,
        DCC_CMD_MODE2  = 4'h2,
        DCC_CMD_OTHER  = 4'h4,
        DCC_CMD_BADPAR = 4'h8
    } dcc_cmd_type;

    typedef enum logic [1:0] {
        DCC_SEQ_IDLE  = 2'h1,
        DCC_SEQ_HALF  = 2'h2
    } dcc_seq_type;
endpackage

// ===== hdl/dcc_spi_link.sv
`include "dcc_consts.svh"

module dcc_spi_link (
    input  wire logic        sys_clk,
    input  wire logic        rstN,
    input  wire logic        spiCsN,
    input  wire logic        spiSclk,
    input  wire logic        spiMosi,
    output logic             spiMisoOut,
    output logic             spiMisoOe,
    input  wire logic [15:0] txWord,
    output logic [15:0]      rxWord,
    output logic             frameDone,
    output logic             frameBad
);
    logic [2:0]  csSync;
    logic [2:0]  sclkSync;
    logic [1:0]  mosiSync;
    logic [15:0] rxShift;
    logic [15:0] txShift;
    logic [4:0]  bitCnt;
    logic        csFall;
    logic        csRise;
    logic        sclkRise;
    logic        sclkFall;

    // bit 0 of each chain is the first synchroniser stage and feeds only bit 1
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            csSync   <= 3'h7;
            sclkSync <= 3'h0;
            mosiSync <= 2'h0;
        end else begin
            csSync   <= {csSync[1:0], spiCsN};
            sclkSync <= {sclkSync[1:0], spiSclk};
            mosiSync <= {mosiSync[0], spiMosi};
        end
    end

    assign csFall   = csSync[2] & ~csSync[1];
    assign csRise   = ~csSync[2] & csSync[1];
    assign sclkRise = ~sclkSync[2] & sclkSync[1] & ~csSync[1];
    assign sclkFall = sclkSync[2] & ~sclkSync[1] & ~csSync[1];

    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            rxShift <= 16'h0000;
            txShift <= 16'h0000;
            bitCnt  <= 5'h00;
        end else if (csFall) begin
            txShift <= txWord;
            bitCnt  <= 5'h00;
        end else begin
            if (sclkRise) begin
                rxShift <= {rxShift[14:0], mosiSync[1]};
                if (bitCnt <= `DCC_FRAME_BITS)
                    bitCnt <= bitCnt + 5'h01;
            end
            if (sclkFall)
                txShift <= {txShift[14:0], 1'b0};
        end
    end

    // a frame of the wrong length is reported so that it can break a sequence
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            rxWord    <= 16'h0000;
            frameDone <= 1'b0;
            frameBad  <= 1'b0;
        end else begin
            frameDone <= csRise && (bitCnt == `DCC_FRAME_BITS);
            frameBad  <= csRise && (bitCnt != `DCC_FRAME_BITS);
            if (csRise && (bitCnt == `DCC_FRAME_BITS))
                rxWord <= rxShift;
        end
    end

    assign spiMisoOut = txShift[15];
    assign spiMisoOe  = ~csSync[2];
endmodule

// ===== hdl/dcc_fen_stretch.sv
`include "dcc_consts.svh"

module dcc_fen_stretch #(
    parameter int STRETCH_UNIT_CYCLES = `DCC_STRETCH_UNIT_CYC
) (
    input  wire logic       sys_clk,
    input  wire logic       rstN,
    input  wire logic       fireEnableInput,
    input  wire logic [1:0] latchTimeBits,
    output logic            fireEnable
);
    logic [1:0]                  inSync;
    logic                        inPrev;
    logic [`DCC_TIMER_BITS-1:0]  timerReg;
    logic [`DCC_TIMER_BITS-1:0]  unitCycles;

    assign unitCycles = `DCC_TIMER_BITS'(STRETCH_UNIT_CYCLES);

    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            inSync <= 2'h0;
            inPrev <= 1'b0;
        end else begin
            inSync <= {inSync[0], fireEnableInput};
            inPrev <= inSync[1];
        end
    end

    // the stretch starts at the input's rising edge; 00 means no stretching
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            timerReg <= '0;
        end else if (inSync[1] && !inPrev) begin
            case (latchTimeBits)
                2'h1:    timerReg <= unitCycles;
                2'h2:    timerReg <= unitCycles << 1;
                2'h3:    timerReg <= unitCycles << 2;
                default: timerReg <= '0;
            endcase
        end else if (timerReg != '0) begin
            timerReg <= timerReg - `DCC_TIMER_BITS'(1);
        end
    end

    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN)
            fireEnable <= 1'b0;
        else
            fireEnable <= inSync[1] | (timerReg != '0);
    end
endmodule

// ===== hdl/dcc_decoder.sv
// Contract
// - top bits 00, bit10 0: mode 1
// - top bits 00, bit11 0, bit10 1: mode 2
// - bit13 makes every word odd parity
// - read command leaves stored settings unchanged
// - mode 1 write: reset step or current
// - bit11 zero: current from bits 9:8
// - bit11 one: low byte is reset step
// - current field selects amps and time
// - mode 1 answer returns stored current
// - mode 1 answer echoes, low byte 0x02
// - soft reset needs 0xAA then 0x55
// - any other frame restarts the sequence
// - soft reset equals power-on, except answer and SPI link
// - answer bit0 shows reset sequence status
// - after soft reset answer is 0x2003
// - mode 2 write sets latch field
// - latch field sets 0/128/256/512 ms
// - four independent fire enable stretch timers
// - mode 2 answer echoes, latch, zero byte
// - latch field resets to 00
// - commands arrive over the first link
`include "dcc_consts.svh"

module dcc_decoder #(
    parameter int STRETCH_UNIT_CYCLES = `DCC_STRETCH_UNIT_CYC
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        spiCsN,
    input  wire logic        spiSclk,
    input  wire logic        spiMosi,
    output logic             spiMisoOut,
    output logic             spiMisoOe,
    input  wire logic [3:0]  fireEnableInput,
    output logic [3:0]       fireEnable,
    output logic [1:0]       currentLevelBits,
    output logic [1:0]       latchTimeBits,
    output logic [10:0]      deployCurrentMa,
    output logic [10:0]      deployTimeUs,
    output logic             softResetPulse
);
    logic                  rstMeta;
    logic                  rstSyncN;
    logic                  coreRstN;
    logic [15:0]           rxWord;
    logic                  frameDone;
    logic                  frameBad;
    logic [15:0]           respReg;
    logic [15:0]           respNext;
    logic [1:0]            currentLevel_reg;
    logic [1:0]            currentLevel_next;
    logic [1:0]            latchTime_reg;
    logic [1:0]            latchTime_next;
    logic                  softReset_reg;
    logic                  softReset_next;
    dcc_pkg::dcc_seq_type  seq_reg;
    dcc_pkg::dcc_seq_type  seq_next;
    dcc_pkg::dcc_cmd_type  cmdClass;
    logic                  isWrite;
    logic                  isResetStep;
    logic [7:0]            lowByte;
    logic [1:0]            fieldBits;

    // returns 1 when the word holds an odd number of ones
    function automatic logic parityOk(input logic [15:0] word);
        parityOk = ^word;
    endfunction

    // fills the parity position so the whole word comes out odd
    function automatic logic [15:0] withParity(input logic [15:0] word);
        logic [15:0] w;
        w = word;
        w[`DCC_BIT_PARITY] = 1'b0;
        w[`DCC_BIT_PARITY] = ~(^w);
        withParity = w;
    endfunction

    // reset released through two flops; assertion stays asynchronous
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta  <= 1'b0;
            rstSyncN <= 1'b0;
        end else begin
            rstMeta  <= 1'b1;
            rstSyncN <= rstMeta;
        end
    end

    // both terms come straight from flops, so the combined reset cannot glitch
    assign coreRstN = rstSyncN & ~softReset_reg;

    // the link is not soft reset, so a frame in flight is never cut short
    dcc_spi_link u_link (
        .sys_clk    (sys_clk),
        .rstN       (rstSyncN),
        .spiCsN     (spiCsN),
        .spiSclk    (spiSclk),
        .spiMosi    (spiMosi),
        .spiMisoOut (spiMisoOut),
        .spiMisoOe  (spiMisoOe),
        .txWord     (respReg),
        .rxWord     (rxWord),
        .frameDone  (frameDone),
        .frameBad   (frameBad)
    );

    assign lowByte   = rxWord[`DCC_LOW_HI:0];
    assign fieldBits = rxWord[`DCC_FIELD_HI:`DCC_FIELD_LO];
    assign isWrite   = rxWord[`DCC_BIT_RW];

    // command classification; parity is checked before the mode bits
    always_comb begin
        if (!parityOk(rxWord))
            cmdClass = dcc_pkg::DCC_CMD_BADPAR;
        else if (rxWord[`DCC_BIT_MODE_HI] || rxWord[`DCC_BIT_MODE_LO])
            cmdClass = dcc_pkg::DCC_CMD_OTHER;
        else if (!rxWord[`DCC_BIT_SEL])
            cmdClass = dcc_pkg::DCC_CMD_MODE1;
        else if (!rxWord[`DCC_BIT_SWR])
            cmdClass = dcc_pkg::DCC_CMD_MODE2;
        else
            cmdClass = dcc_pkg::DCC_CMD_OTHER;
    end

    assign isResetStep = (cmdClass == dcc_pkg::DCC_CMD_MODE1) && isWrite
                         && rxWord[`DCC_BIT_SWR];

    // current level: only a mode 1 write with the reset select low moves it
    always_comb begin
        currentLevel_next = currentLevel_reg;
        if (frameDone && (cmdClass == dcc_pkg::DCC_CMD_MODE1) && isWrite
            && !rxWord[`DCC_BIT_SWR])
            currentLevel_next = fieldBits;
    end

    always_comb begin
        latchTime_next = latchTime_reg;
        if (frameDone && (cmdClass == dcc_pkg::DCC_CMD_MODE2) && isWrite)
            latchTime_next = fieldBits;
    end

    // two-frame soft reset sequence; every completed or broken frame is a step
    always_comb begin
        seq_next       = seq_reg;
        softReset_next = 1'b0;
        if (frameBad) begin
            seq_next = dcc_pkg::DCC_SEQ_IDLE;
        end else if (frameDone) begin
            case (seq_reg)
                dcc_pkg::DCC_SEQ_IDLE: begin
                    if (isResetStep && (lowByte == `DCC_SEQ_FIRST))
                        seq_next = dcc_pkg::DCC_SEQ_HALF;
                end
                dcc_pkg::DCC_SEQ_HALF: begin
                    if (isResetStep && (lowByte == `DCC_SEQ_SECOND)) begin
                        seq_next       = dcc_pkg::DCC_SEQ_IDLE;
                        softReset_next = 1'b1;
                    end else if (isResetStep && (lowByte == `DCC_SEQ_FIRST)) begin
                        seq_next = dcc_pkg::DCC_SEQ_HALF;
                    end else begin
                        seq_next = dcc_pkg::DCC_SEQ_IDLE;
                    end
                end
                default: seq_next = dcc_pkg::DCC_SEQ_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge coreRstN) begin
        if (!coreRstN)
            seq_reg <= dcc_pkg::DCC_SEQ_IDLE;
        else
            seq_reg <= seq_next;
    end

    always_ff @(posedge sys_clk or negedge coreRstN) begin
        if (!coreRstN) begin
            currentLevel_reg <= `DCC_CL_DEFAULT;
            latchTime_reg    <= `DCC_LATCH_DEFAULT;
        end else begin
            currentLevel_reg <= currentLevel_next;
            latchTime_reg    <= latchTime_next;
        end
    end

    // the pulse clears itself: it is reset only by the pin reset
    always_ff @(posedge sys_clk or negedge rstSyncN) begin
        if (!rstSyncN)
            softReset_reg <= 1'b0;
        else
            softReset_reg <= softReset_next;
    end

    // answer word for the next frame, built from the already updated settings
    always_comb begin
        respNext = respReg;
        if (frameDone) begin
            case (cmdClass)
                dcc_pkg::DCC_CMD_MODE1: begin
                    if (softReset_next)
                        respNext = `DCC_RESET_DONE_RESP;
                    else
                        respNext = withParity({2'b00, 1'b0, isWrite,
                                               rxWord[`DCC_BIT_SWR], 1'b0,
                                               currentLevel_next,
                                               `DCC_MODE1_LOW});
                end
                dcc_pkg::DCC_CMD_MODE2: begin
                    respNext = withParity({2'b00, 1'b0, isWrite, 1'b0, 1'b1,
                                           latchTime_next, 8'h00});
                end
                dcc_pkg::DCC_CMD_BADPAR: respNext = `DCC_INVALID_RESP;
                dcc_pkg::DCC_CMD_OTHER:  respNext = `DCC_INVALID_RESP;
                default:                 respNext = `DCC_INVALID_RESP;
            endcase
        end else if (frameBad) begin
            respNext = `DCC_INVALID_RESP;
        end
    end

    // survives a soft reset so that 0x2003 reaches the master
    always_ff @(posedge sys_clk or negedge rstSyncN) begin
        if (!rstSyncN)
            respReg <= `DCC_RESP_RESET;
        else
            respReg <= respNext;
    end

    // decoded firing condition for the driver stage
    always_ff @(posedge sys_clk or negedge coreRstN) begin
        if (!coreRstN) begin
            deployCurrentMa <= `DCC_CUR_MA_1200;
            deployTimeUs    <= `DCC_TIME_US_2000;
        end else begin
            case (currentLevel_reg)
                2'h1: begin
                    deployCurrentMa <= `DCC_CUR_MA_1500;
                    deployTimeUs    <= `DCC_TIME_US_2000;
                end
                2'h2: begin
                    deployCurrentMa <= `DCC_CUR_MA_1750;
                    deployTimeUs    <= `DCC_TIME_US_650;
                end
                2'h3: begin
                    deployCurrentMa <= `DCC_CUR_MA_1750;
                    deployTimeUs    <= `DCC_TIME_US_1000;
                end
                default: begin
                    deployCurrentMa <= `DCC_CUR_MA_1200;
                    deployTimeUs    <= `DCC_TIME_US_2000;
                end
            endcase
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < 4; ch++) begin : g_fen
            dcc_fen_stretch #(
                .STRETCH_UNIT_CYCLES (STRETCH_UNIT_CYCLES)
            ) u_fen (
                .sys_clk         (sys_clk),
                .rstN            (coreRstN),
                .fireEnableInput (fireEnableInput[ch]),
                .latchTimeBits   (latchTime_reg),
                .fireEnable      (fireEnable[ch])
            );
        end
    endgenerate

    assign currentLevelBits = currentLevel_reg;
    assign latchTimeBits    = latchTime_reg;
    assign softResetPulse   = softReset_reg;
endmodule

// ===== verification/dcc_decoder_chk.sv
module dcc_decoder_chk #(
    parameter int STRETCH_UNIT_CYCLES = 20
) (
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        spiCsN,
    input wire logic        spiSclk,
    input wire logic        spiMosi,
    input wire logic        spiMisoOut,
    input wire logic        spiMisoOe,
    input wire logic [3:0]  fireEnableInput,
    input wire logic [3:0]  fireEnable,
    input wire logic [1:0]  currentLevelBits,
    input wire logic [1:0]  latchTimeBits,
    input wire logic [10:0] deployCurrentMa,
    input wire logic [10:0] deployTimeUs,
    input wire logic        softResetPulse
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    int unsigned idleCnt;

    function automatic logic [10:0] ampsOf(input logic [1:0] c);
        return (c == 2'h0) ? 11'h4B0 : (c == 2'h1) ? 11'h5DC : 11'h6D6;
    endfunction

    function automatic logic [10:0] usOf(input logic [1:0] c);
        return (c[1] == 1'b0) ? 11'h7D0 : (c == 2'h2) ? 11'h28A : 11'h3E8;
    endfunction

    // cycles with all pins low; saturates at 0xFFFF, above the longest stretch only when STRETCH_UNIT_CYCLES is small, as in the testbench
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            idleCnt <= 0;
        end else if (fireEnableInput != 4'h0) begin
            idleCnt <= 0;
        end else if (idleCnt < 32'hFFFF) begin
            idleCnt <= idleCnt + 1;
        end
    end

    sequence s_defaults;
        currentLevelBits == 2'h0 && latchTimeBits == 2'h0 ##1
            deployCurrentMa == 11'h4B0 && deployTimeUs == 11'h7D0;
    endsequence

    property p_cur_map;
        $stable(currentLevelBits) |-> deployCurrentMa == ampsOf(currentLevelBits);
    endproperty
    a_cur_map: assert property (p_cur_map) else $error("current off table");

    property p_time_map;
        $stable(currentLevelBits) |-> deployTimeUs == usOf(currentLevelBits);
    endproperty
    a_time_map: assert property (p_time_map) else $error("time off table");

    property p_quiet;
        (!spiCsN) [*8] |-> $stable(currentLevelBits) && $stable(latchTimeBits);
    endproperty
    a_quiet: assert property (p_quiet) else $error("setting moved mid frame");

    property p_soft_clear;
        softResetPulse |-> ##2 s_defaults;
    endproperty
    a_soft_clear: assert property (p_soft_clear) else $error("soft reset left state");

    property p_pulse_frame;
        softResetPulse |-> spiCsN ##1 !softResetPulse;
    endproperty
    a_pulse_frame: assert property (p_pulse_frame) else $error("bad reset pulse");

    property p_oe;
        ($stable(spiCsN)) [*4] |-> spiMisoOe == !spiCsN;
    endproperty
    a_oe: assert property (p_oe) else $error("data out enable wrong");

    property p_fen_follow;
        (fireEnableInput & $past(fireEnableInput) & $past(fireEnableInput, 2)
            & $past(fireEnableInput, 3) & $past(fireEnableInput, 4) & ~fireEnable) == 4'h0;
    endproperty
    a_fen_follow: assert property (p_fen_follow) else $error("enable not passed");

    property p_fen_bounded;
        idleCnt > 4 * STRETCH_UNIT_CYCLES + 8 |-> fireEnable == 4'h0;
    endproperty
    a_fen_bounded: assert property (p_fen_bounded) else $error("stretch too long");
endmodule

// ===== verification/dcc_spi_master.sv
module dcc_spi_master (
    input  wire logic sys_clk,
    output logic      spiCsN,
    output logic      spiSclk,
    output logic      spiMosi,
    input  wire logic spiMisoOut,
    input  wire logic spiMisoOe
);
    timeunit 1ns;
    timeprecision 1ps;

    logic lastBit = 1'b0;
    // a released data line is not trusted to hold its last bit
    wire logic misoLine = spiMisoOe ? spiMisoOut : ~lastBit;

    initial begin
        spiCsN = 1'b1;
        spiSclk = 1'b0;
        spiMosi = 1'b0;
    end

    function automatic logic [15:0] withPar(input logic [15:0] w, input logic good);
        logic [15:0] v;
        v = w & 16'hDFFF;
        v[13] = ~(^v) ^ ~good;
        return v;
    endfunction

    task automatic waitClk(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // mode 0, msb first; sclk period 65 ns, 13 sys_clk steps
    task automatic xfer(input logic [15:0] cmd, input logic good, output logic [15:0] ans);
        logic [15:0] w;
        w = withPar(cmd, good);
        waitClk(1);
        spiCsN <= 1'b0;
        waitClk(4);
        for (int i = 15; i >= 0; i--) begin
            spiMosi <= w[i];
            waitClk(7);
            spiSclk <= 1'b1;
            ans[i] = misoLine;
            lastBit <= misoLine;
            waitClk(6);
            spiSclk <= 1'b0;
        end
        waitClk(7);
        spiCsN <= 1'b1;
        spiMosi <= ~w[0];
        waitClk(10);
    endtask
endmodule

// ===== verification/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int UNIT = 20;
    localparam logic [10:0] AMPS [4] = '{11'h4B0, 11'h5DC, 11'h6D6, 11'h6D6};
    localparam logic [10:0] USEC [4] = '{11'h7D0, 11'h7D0, 11'h28A, 11'h3E8};

    logic        sys_clk;
    logic        rst_n = 1'b0;
    logic        spiCsN;
    logic        spiSclk;
    logic        spiMosi;
    logic        spiMisoOut;
    logic        spiMisoOe;
    logic [3:0]  fireEnableInput = 4'h0;
    logic [3:0]  fireEnable;
    logic [1:0]  currentLevelBits;
    logic [1:0]  latchTimeBits;
    logic [10:0] deployCurrentMa;
    logic [10:0] deployTimeUs;
    logic        softResetPulse;
    logic [15:0] prevAns;
    int          errors = 0;
    int          tests_run = 0;
    int          cycles = 0;
    int          pulses = 0;

    dcc_decoder #(.STRETCH_UNIT_CYCLES(UNIT)) DUT (
        .sys_clk(sys_clk), .rst_n(rst_n), .spiCsN(spiCsN), .spiSclk(spiSclk),
        .spiMosi(spiMosi), .spiMisoOut(spiMisoOut), .spiMisoOe(spiMisoOe),
        .fireEnableInput(fireEnableInput), .fireEnable(fireEnable),
        .currentLevelBits(currentLevelBits), .latchTimeBits(latchTimeBits),
        .deployCurrentMa(deployCurrentMa), .deployTimeUs(deployTimeUs),
        .softResetPulse(softResetPulse)
    );

    dcc_spi_master master (
        .sys_clk(sys_clk), .spiCsN(spiCsN), .spiSclk(spiSclk), .spiMosi(spiMosi),
        .spiMisoOut(spiMisoOut), .spiMisoOe(spiMisoOe)
    );

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic end_of_test();
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (softResetPulse === 1'b1) pulses <= pulses + 1;
        if (cycles == 30000) begin
            errors++;
            end_of_test();
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [15:0] p(input logic [15:0] w);
        return master.withPar(w, 1'b1);
    endfunction

    // the answer shifted out belongs to the frame before
    task automatic frame(input logic [15:0] cmd, input logic good, input logic [15:0] expAns);
        logic [15:0] ans;
        master.xfer(cmd, good, ans);
        check("answer", ans, expAns);
    endtask

    task automatic cfg(input logic [1:0] cl, input logic [1:0] lt);
        check("level", {14'h0, currentLevelBits}, {14'h0, cl});
        check("latch", {14'h0, latchTimeBits}, {14'h0, lt});
        check("amps", {5'h0, deployCurrentMa}, {5'h0, AMPS[cl]});
        check("usec", {5'h0, deployTimeUs}, {5'h0, USEC[cl]});
    endtask

    task automatic fenPulse(input int ch, input int dur);
        fireEnableInput <= 4'h1 << ch;
        repeat (5) @(posedge sys_clk);
        fireEnableInput <= 4'h0;
        if (dur > 0) begin
            repeat (dur - 4) @(posedge sys_clk);
            #1 check("stretched", {12'h0, fireEnable}, {12'h0, 4'h1 << ch});
        end
        repeat (12) @(posedge sys_clk);
        #1 check("released", {12'h0, fireEnable}, 16'h0000);
    endtask

    initial begin
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge sys_clk);
        cfg(2'h0, 2'h0);
        frame(16'h0000, 1'b1, 16'h2000);
        prevAns = p(16'h0002);
        for (int i = 0; i < 4; i++) begin
            frame(16'h103C | (16'(i ^ 1) << 8), 1'b1, prevAns);
            prevAns = p(16'h1002 | (16'(i ^ 1) << 8));
            cfg(2'(i ^ 1), 2'h0);
        end
        frame(16'h0B00, 1'b1, prevAns);
        prevAns = p(16'h0A02);
        cfg(2'h2, 2'h0);
        for (int i = 0; i < 4; i++) begin
            frame(16'h1400 | (16'(i ^ 2) << 8), 1'b1, prevAns);
            prevAns = p(16'h1400 | (16'(i ^ 2) << 8));
            cfg(2'h2, 2'(i ^ 2));
        end
        frame(16'h0700, 1'b1, prevAns);
        frame(16'h1300, 1'b0, p(16'h0500));
        frame(16'h1C00, 1'b1, 16'h2000);
        // non-zero mode bits must not be taken as a level write
        frame(16'hD300, 1'b1, 16'h2000);
        cfg(2'h2, 2'h1);
        frame(16'h18AA, 1'b1, 16'h2000);
        frame(16'h0400, 1'b1, p(16'h1A02));
        frame(16'h1855, 1'b1, p(16'h0500));
        frame(16'h18AA, 1'b1, p(16'h1A02));
        frame(16'h1856, 1'b1, p(16'h1A02));
        frame(16'h18AA, 1'b1, p(16'h1A02));
        frame(16'h1855, 1'b0, p(16'h1A02));
        check("resets", 16'(pulses), 16'h0000);
        cfg(2'h2, 2'h1);
        frame(16'h18AA, 1'b1, 16'h2000);
        frame(16'h1855, 1'b1, p(16'h1A02));
        check("resets", 16'(pulses), 16'h0001);
        cfg(2'h0, 2'h0);
        frame(16'h0000, 1'b1, 16'h2003);
        for (int ch = 0; ch < 4; ch++) begin
            master.xfer(16'h1400 | (16'(ch) << 8), 1'b1, prevAns);
            fenPulse(ch, UNIT * ((ch == 3) ? 4 : ch));
        end
        end_of_test();
    end
endmodule

bind dcc_decoder dcc_decoder_chk #(.STRETCH_UNIT_CYCLES(STRETCH_UNIT_CYCLES)) chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .spiCsN(spiCsN), .spiSclk(spiSclk),
    .spiMosi(spiMosi), .spiMisoOut(spiMisoOut), .spiMisoOe(spiMisoOe),
    .fireEnableInput(fireEnableInput), .fireEnable(fireEnable),
    .currentLevelBits(currentLevelBits), .latchTimeBits(latchTimeBits),
    .deployCurrentMa(deployCurrentMa), .deployTimeUs(deployTimeUs),
    .softResetPulse(softResetPulse)
);
